/* File: design/lp_seq_pkg.sv */
// ==========================================
// power sequencer constants and carriers
package lp_seq_pkg;
  // number of low-power operating modes
  localparam int unsigned NUM_LP_MODES = 3;
  // number of gated high-speed clock consumers
  localparam int unsigned NUM_BLOCKS = 8;
  localparam int unsigned RET_WORDS = 16;
  localparam int unsigned RET_AW = 4;
  localparam int unsigned RET_DW = 32;
  localparam int unsigned RTC_W = 32;
  // powered_mode encoding seen by software
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_DEEP = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  localparam logic [NUM_BLOCKS-1:0] CLK_CTRL_RESET = 8'h00;
  localparam logic [RTC_W-1:0] RTC_RESET = 32'h0000_0000;

  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_DEEP = 5'b00010,
    ST_SLEEP = 5'b00100,
    ST_WAKE = 5'b01000,
    ST_ON = 5'b10000
  } pwr_state_e;

  typedef struct packed {
    logic mac;
    logic host;
    logic rtc_timer;
    logic ext_irq;
  } wake_src_s;

  typedef struct packed {
    logic rtc_domain_pwr;
    logic main_domain_pwr;
    logic xtal_en;
    logic pll_en;
    logic [1:0] powered_mode;
  } pwr_ctrl_s;

  typedef struct packed {
    logic we;
    logic [RET_AW-1:0] addr;
    logic [RET_DW-1:0] wdata;
  } ret_req_s;
endpackage : lp_seq_pkg

/* File: design/rtc_domain.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// always-on domain: timer and retention memory
module rtc_domain (
  // clock and clear
  input wire logic ref_clk_i,
  input wire logic rtc_clear_i,
  input wire logic rtc_run_i,
  // retention access
  input wire lp_seq_pkg::ret_req_s ret_req_i,
  output logic [lp_seq_pkg::RET_DW-1:0] ret_rdata_o,
  // timer
  input wire logic [lp_seq_pkg::RTC_W-1:0] rtc_alarm_i,
  output logic [lp_seq_pkg::RTC_W-1:0] rtc_count_o,
  output logic rtc_wake_o
);
  import lp_seq_pkg::*;
  logic [RET_DW-1:0] ret_mem [RET_WORDS];
  logic [RTC_W-1:0] count_reg;
  logic [RET_DW-1:0] rdata_reg;
  logic wake_reg;
  wire alarm_hit = (count_reg == rtc_alarm_i) && (rtc_alarm_i != RTC_RESET);

  // no sleep input here: the domain only stops when the chip is off
  always_ff @(posedge ref_clk_i) begin
    if (rtc_clear_i) begin
      count_reg <= RTC_RESET;
      wake_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      if (rtc_run_i) begin
        count_reg <= count_reg + 32'h1;
      end
      wake_reg <= alarm_hit;
      rdata_reg <= ret_mem[ret_req_i.addr];
    end
  end

  // memory is wiped one word per cycle while off; contents survive every sleep
  logic [RET_AW-1:0] wipe_reg;
  always_ff @(posedge ref_clk_i) begin
    if (rtc_clear_i) begin
      wipe_reg <= wipe_reg + 4'h1;
      ret_mem[wipe_reg] <= '0;
    end else begin
      // restart the sweep so every power-down wipes from word 0 upward; all 16 words need 16 cycles off
      wipe_reg <= '0;
      if (ret_req_i.we) begin
        ret_mem[ret_req_i.addr] <= ret_req_i.wdata;
      end
    end
  end

  assign rtc_count_o = count_reg;
  assign ret_rdata_o = rdata_reg;
  assign rtc_wake_o = wake_reg;
endmodule : rtc_domain
`default_nettype wire

/* File: design/low_power_state_sequencer.sv */
// Operation
// - three modes: active, sleep and deep sleep, chosen by software requests
// - chip enable low means off: rtc disabled, all state cleared
// - deep sleep powers only the rtc domain
// - rtc retention memory survives deep sleep
// - rtc clock keeps counting in deep sleep
// - sleep keeps only rtc logic running, crystal held off
// - any mac, host, rtc or external wake in sleep enters wake-up
// - wake-up enables crystal oscillator and plls
// - wake-up leads from either sleep state to on
// - on: high-speed clock only to blocks enabled in clock control
// - each block gates its clock further locally
// - wait-for-interrupt gates cpu clock until cpu wakes
// - deep-sleep wake output is wired back to external reset
// - external reset is active low
`timescale 1ns/100ps
`default_nettype none
module low_power_state_sequencer (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // board pins
  input wire logic power_on_enable_pin_i,
  input wire logic external_reset_n_pin_i,
  output logic deep_sleep_wake_out_o,
  // software requests
  input wire logic sleep_req_i,
  input wire logic deep_sleep_req_i,
  input wire logic [lp_seq_pkg::NUM_BLOCKS-1:0] clk_ctrl_i,
  input wire logic clk_ctrl_we_i,
  input wire logic [lp_seq_pkg::NUM_BLOCKS-1:0] block_local_en_i,
  input wire logic wait_for_interrupt_insn_i,
  input wire logic cpu_irq_i,
  // wake events
  input wire lp_seq_pkg::wake_src_s wake_src_i,
  // analog status
  input wire logic xtal_stable_i,
  input wire logic pll_locked_i,
  // rtc access
  input wire lp_seq_pkg::ret_req_s ret_req_i,
  input wire logic [lp_seq_pkg::RTC_W-1:0] rtc_alarm_i,
  output logic [lp_seq_pkg::RET_DW-1:0] ret_rdata_o,
  output logic [lp_seq_pkg::RTC_W-1:0] rtc_count_o,
  // power and clock controls
  output lp_seq_pkg::pwr_ctrl_s pwr_ctrl_o,
  output logic [lp_seq_pkg::NUM_BLOCKS-1:0] block_clk_en_o,
  output logic cpu_clk_en_o,
  output logic [4:0] state_o
);
  import lp_seq_pkg::*;

  // ==========================================
  // pin synchronisers
  // pins and analog status flags cross in through two flops before any decode
  logic [1:0] pu_sync_reg;
  logic [1:0] rst_sync_reg;
  logic [1:0] wake_sync_reg;
  logic [1:0] xtal_sync_reg;
  logic [1:0] pll_sync_reg;
  wire chip_on = pu_sync_reg[1];
  wire ext_rst_active = ~rst_sync_reg[1];
  wire ext_wake = wake_sync_reg[1];

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pu_sync_reg <= 2'b00;
      rst_sync_reg <= 2'b00;
      wake_sync_reg <= 2'b00;
      xtal_sync_reg <= 2'b00;
      pll_sync_reg <= 2'b00;
    end else begin
      pu_sync_reg <= {pu_sync_reg[0], power_on_enable_pin_i};
      rst_sync_reg <= {rst_sync_reg[0], external_reset_n_pin_i};
      wake_sync_reg <= {wake_sync_reg[0], wake_src_i.ext_irq};
      xtal_sync_reg <= {xtal_sync_reg[0], xtal_stable_i};
      pll_sync_reg <= {pll_sync_reg[0], pll_locked_i};
    end
  end

  // ==========================================
  // rtc domain
  logic rtc_wake;
  wire rtc_clear = sys_rst_i | ~chip_on;
  rtc_domain u_rtc (
    .ref_clk_i(ref_clk_i),
    .rtc_clear_i(rtc_clear),
    .rtc_run_i(chip_on),
    .ret_req_i(ret_req_i),
    .ret_rdata_o(ret_rdata_o),
    .rtc_alarm_i(rtc_alarm_i),
    .rtc_count_o(rtc_count_o),
    .rtc_wake_o(rtc_wake)
  );

  // ==========================================
  // state machine
  pwr_state_e state_reg, state_next;
  logic deep_wake_reg;
  wire any_wake = wake_src_i.mac | wake_src_i.host | wake_src_i.rtc_timer
    | rtc_wake | ext_wake;
  // lock is trusted only once both analog flags have crossed into this clock
  wire clocks_ready = xtal_sync_reg[1] & pll_sync_reg[1];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (chip_on && !ext_rst_active) begin
          state_next = ST_WAKE;
        end
      end
      ST_ON: begin
        if (deep_sleep_req_i) begin
          state_next = ST_DEEP;
        end else if (sleep_req_i) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_wake) begin
          state_next = ST_WAKE;
        end
      end
      // deep sleep only ends through the external reset loop
      ST_DEEP: begin
        if (ext_rst_active) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (clocks_ready && !ext_rst_active) begin
          state_next = ST_ON;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    // a held external reset parks every powered state in wake-up
    if (ext_rst_active && (state_reg != ST_OFF)) begin
      state_next = ST_WAKE;
    end
    if (!chip_on) begin
      state_next = ST_OFF;
    end
  end

  // pulse the wake line low-going via reset: drive high on rtc alarm in deep sleep
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_OFF;
      deep_wake_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      deep_wake_reg <= (state_reg == ST_DEEP) && rtc_wake;
    end
  end

  // ==========================================
  // mode decode
  // illegal one-hot codes read back as off
  function automatic logic [1:0] mode_of(input pwr_state_e st);
    logic [1:0] code;
    code = MODE_OFF;
    case (st)
      ST_ON, ST_WAKE: begin
        code = MODE_ACTIVE;
      end
      ST_SLEEP: begin
        code = MODE_SLEEP;
      end
      ST_DEEP: begin
        code = MODE_DEEP;
      end
      default: begin
        code = MODE_OFF;
      end
    endcase
    return code;
  endfunction : mode_of

  // ==========================================
  // power and clock outputs
  logic [NUM_BLOCKS-1:0] clk_ctrl_reg;
  logic wfi_reg;
  pwr_ctrl_s pwr_next;
  wire in_on = (state_reg == ST_ON);
  wire in_wake = (state_reg == ST_WAKE);
  wire in_sleep = (state_reg == ST_SLEEP);

  always_comb begin
    pwr_next.rtc_domain_pwr = (state_reg != ST_OFF);
    pwr_next.main_domain_pwr = in_on | in_wake | in_sleep;
    pwr_next.xtal_en = in_on | in_wake;
    pwr_next.pll_en = in_on | in_wake;
    pwr_next.powered_mode = mode_of(state_reg);
  end

  // cpu stays gated across a wfi until an interrupt or until the state leaves on; a wake event in on is not enough
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !chip_on) begin
      clk_ctrl_reg <= CLK_CTRL_RESET;
      wfi_reg <= 1'b0;
      pwr_ctrl_o <= '0;
      block_clk_en_o <= '0;
      cpu_clk_en_o <= 1'b0;
    end else begin
      if (clk_ctrl_we_i) begin
        clk_ctrl_reg <= clk_ctrl_i;
      end
      if (!in_on || cpu_irq_i) begin
        wfi_reg <= 1'b0;
      end else if (wait_for_interrupt_insn_i) begin
        wfi_reg <= 1'b1;
      end
      pwr_ctrl_o <= pwr_next;
      block_clk_en_o <= {NUM_BLOCKS{in_on}} & clk_ctrl_reg & block_local_en_i;
      cpu_clk_en_o <= in_on & ~wfi_reg & ~(wait_for_interrupt_insn_i & ~cpu_irq_i);
    end
  end

  assign deep_sleep_wake_out_o = deep_wake_reg;
  assign state_o = state_reg;
endmodule : low_power_state_sequencer
`default_nettype wire

/* File: tb/board_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// board: reset strap and oscillator settling
module board_model (
  input wire logic ref_clk_i,
  input wire logic wake_out_i,
  input wire logic osc_en_i,
  input wire logic stall_i,
  output logic rst_n_o,
  output logic osc_ok_o
);
  logic [3:0] rst_cnt_reg = 4'h0;
  logic [3:0] osc_cnt_reg = 4'h0;
  // wake output strapped to the active-low reset pin
  assign rst_n_o = (rst_cnt_reg == 4'h0);
  // stall models a slow crystal, so lock may take a while
  assign osc_ok_o = (osc_cnt_reg == 4'hf);
  always_ff @(posedge ref_clk_i) begin
    if (wake_out_i) rst_cnt_reg <= 4'h8;
    else if (rst_cnt_reg != 4'h0) rst_cnt_reg <= rst_cnt_reg - 4'h1;
    if (!osc_en_i) osc_cnt_reg <= 4'h0;
    else if (!stall_i && !osc_ok_o) osc_cnt_reg <= osc_cnt_reg + 4'h1;
  end
endmodule : board_model
`default_nettype wire

/* File: tb/lp_seq_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker
module lp_seq_properties
  import lp_seq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic power_on_enable_pin_i,
  input wire logic external_reset_n_pin_i,
  input wire wake_src_s wake_src_i,
  input wire logic xtal_stable_i,
  input wire logic pll_locked_i,
  input wire logic wait_for_interrupt_insn_i,
  input wire logic cpu_irq_i,
  input wire logic [NUM_BLOCKS-1:0] block_local_en_i,
  input wire logic deep_sleep_wake_out_o,
  input wire logic [RTC_W-1:0] rtc_count_o,
  input wire pwr_ctrl_s pwr_ctrl_o,
  input wire logic [NUM_BLOCKS-1:0] block_clk_en_o,
  input wire logic cpu_clk_en_o,
  input wire logic [4:0] state_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_off_clears: assert property (!power_on_enable_pin_i [*3] |=> state_o == 5'h01)
    else $error("not off while chip enable low");
  chk_wake_lock: assert property (state_o == 5'h08
    && !($past(xtal_stable_i, 2) && $past(pll_locked_i, 2))
    |=> state_o != 5'h10) else $error("left wake-up without lock");
  chk_ext_reset_hold: assert property (!external_reset_n_pin_i [*3]
    |=> state_o inside {5'h01, 5'h08}) else $error("external reset did not hold device");
  chk_wake_osc: assert property (state_o == 5'h08 |=> pwr_ctrl_o.xtal_en && pwr_ctrl_o.pll_en)
    else $error("oscillator off in wake-up");
  chk_deep_power: assert property (state_o == 5'h02 |=> pwr_ctrl_o.rtc_domain_pwr
    && !pwr_ctrl_o.main_domain_pwr && pwr_ctrl_o.powered_mode == MODE_DEEP)
    else $error("deep sleep power wrong");
  chk_sleep_osc: assert property (state_o == 5'h04 |=> !pwr_ctrl_o.xtal_en
    && pwr_ctrl_o.powered_mode == MODE_SLEEP) else $error("sleep controls wrong");
  chk_sleep_wake: assert property (state_o == 5'h04 && power_on_enable_pin_i
    && (wake_src_i.mac || wake_src_i.host) |-> ##[1:4] state_o == 5'h08)
    else $error("wake event ignored");
  chk_gate_mask: assert property (state_o == 5'h10
    |=> (block_clk_en_o & ~$past(block_local_en_i)) == '0) else $error("clock not locally gated");
  chk_idle_gated: assert property (state_o inside {5'h01, 5'h02, 5'h04}
    |=> block_clk_en_o == '0) else $error("block clock runs when not on");
  chk_wfi_gate: assert property (state_o == 5'h10 && wait_for_interrupt_insn_i && !cpu_irq_i
    |=> !cpu_clk_en_o) else $error("cpu clock not gated");
  chk_rtc_counts: assert property ((state_o == 5'h02) [*2]
    |=> rtc_count_o != $past(rtc_count_o)) else $error("rtc stopped in deep sleep");
  chk_wake_out: assert property (deep_sleep_wake_out_o |-> $past(state_o) == 5'h02)
    else $error("wake output outside deep sleep");
  cover property (state_o == 5'h10 ##1 state_o == 5'h04);
  cover property (state_o == 5'h02 ##1 state_o == 5'h08);
  cover property (deep_sleep_wake_out_o);
endmodule : lp_seq_properties
bind low_power_state_sequencer lp_seq_properties lp_seq_properties_inst (.*);
`default_nettype wire

/* File: tb/low_power_state_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// sequencer bench
module low_power_state_sequencer_tb;
  import lp_seq_pkg::*;
  logic ref_clk_i, sys_rst_i, power_on_enable_pin_i, external_reset_n_pin_i;
  logic deep_sleep_wake_out_o, sleep_req_i, deep_sleep_req_i, clk_ctrl_we_i;
  logic wait_for_interrupt_insn_i, cpu_irq_i, xtal_stable_i, pll_locked_i, cpu_clk_en_o, stall;
  logic [NUM_BLOCKS-1:0] clk_ctrl_i, block_local_en_i, block_clk_en_o;
  logic [RTC_W-1:0] rtc_alarm_i, rtc_count_o, cnt;
  logic [RET_DW-1:0] ret_rdata_o;
  logic [4:0] state_o;
  wake_src_s wake_src_i;
  ret_req_s ret_req_i;
  pwr_ctrl_s pwr_ctrl_o;
  int mismatches = 0;
  int checks_done = 0;
  low_power_state_sequencer low_power_state_sequencer_inst (.*);
  board_model board_model_inst (.ref_clk_i(ref_clk_i), .wake_out_i(deep_sleep_wake_out_o),
    .osc_en_i(pwr_ctrl_o.xtal_en), .stall_i(stall), .rst_n_o(external_reset_n_pin_i),
    .osc_ok_o(xtal_stable_i));
  assign pll_locked_i = xtal_stable_i;
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc
  task automatic wait_st(input logic [4:0] st);
    int n;
    n = 0;
    while (state_o !== st && n < 300) begin
      cyc(1);
      n++;
    end
    chk("state", {27'h0, st}, {27'h0, state_o});
    cyc(2);
  endtask : wait_st
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic t_power_up;
    power_on_enable_pin_i = 1'b1;
    wait_st(5'h08);
    cyc(20);
    chk("held in wake", 32'h8, {27'h0, state_o});
    chk("xtal pll", 32'h3, {30'h0, pwr_ctrl_o.xtal_en, pwr_ctrl_o.pll_en});
    stall = 1'b0;
    wait_st(5'h10);
    chk("mode", {30'h0, MODE_ACTIVE}, {30'h0, pwr_ctrl_o.powered_mode});
  endtask : t_power_up
  task automatic t_gating;
    clk_ctrl_i = 8'h5a;
    clk_ctrl_we_i = 1'b1;
    block_local_en_i = 8'h0f;
    cyc(1);
    clk_ctrl_we_i = 1'b0;
    cyc(3);
    chk("blk clk", 32'h0a, {24'h0, block_clk_en_o});
    block_local_en_i = 8'hff;
    cyc(3);
    chk("blk clk", 32'h5a, {24'h0, block_clk_en_o});
  endtask : t_gating
  task automatic t_wfi;
    chk("cpu", 32'h1, {31'h0, cpu_clk_en_o});
    wait_for_interrupt_insn_i = 1'b1;
    cyc(1);
    wait_for_interrupt_insn_i = 1'b0;
    cyc(6);
    chk("cpu gated", 32'h0, {31'h0, cpu_clk_en_o});
    cpu_irq_i = 1'b1;
    cyc(3);
    chk("cpu woken", 32'h1, {31'h0, cpu_clk_en_o});
    cpu_irq_i = 1'b0;
  endtask : t_wfi
  task automatic t_sleep(input wake_src_s src);
    sleep_req_i = 1'b1;
    wait_st(5'h04);
    sleep_req_i = 1'b0;
    chk("sleep", {29'h0, MODE_SLEEP, 1'b0}, {29'h0, pwr_ctrl_o.powered_mode, pwr_ctrl_o.xtal_en});
    wake_src_i = src;
    wait_st(5'h10);
    wake_src_i = '0;
  endtask : t_sleep
  task automatic t_deep;
    ret_req_i = '{we: 1'b1, addr: 4'h5, wdata: 32'hc0de_5a17};
    cyc(1);
    ret_req_i.we = 1'b0;
    deep_sleep_req_i = 1'b1;
    wait_st(5'h02);
    deep_sleep_req_i = 1'b0;
    chk("deep pwr", 32'h2, {30'h0, pwr_ctrl_o.rtc_domain_pwr, pwr_ctrl_o.main_domain_pwr});
    cnt = rtc_count_o;
    cyc(4);
    chk("rtc runs", 32'h1, {31'h0, rtc_count_o !== cnt});
    rtc_alarm_i = rtc_count_o + 32'h14;
    wait_st(5'h08);
    rtc_alarm_i = '0;
    wait_st(5'h10);
    chk("retained", 32'hc0de_5a17, ret_rdata_o);
  endtask : t_deep
  task automatic t_off;
    power_on_enable_pin_i = 1'b0;
    wait_st(5'h01);
    cyc(20);
    chk("rtc cleared", 32'h0, rtc_count_o);
    chk("pwr cleared", 32'h0, {26'h0, pwr_ctrl_o});
    power_on_enable_pin_i = 1'b1;
    wait_st(5'h10);
    chk("ret wiped", 32'h0, ret_rdata_o);
  endtask : t_off
  initial begin
    {sys_rst_i, power_on_enable_pin_i, sleep_req_i, deep_sleep_req_i, clk_ctrl_we_i} = 5'h10;
    {wait_for_interrupt_insn_i, cpu_irq_i, stall} = 3'h1;
    clk_ctrl_i = '0;
    block_local_en_i = '0;
    rtc_alarm_i = '0;
    wake_src_i = '0;
    ret_req_i = '0;
    cyc(3);
    sys_rst_i = 1'b0;
    t_power_up();
    t_gating();
    t_wfi();
    t_sleep(4'h8);
    t_sleep(4'h4);
    t_sleep(4'h2);
    t_sleep(4'h1);
    t_deep();
    t_off();
    give_verdict();
  end
  // bound covers every scenario with wide margin
  initial begin
    cyc(8000);
    mismatches++;
    give_verdict();
  end
endmodule : low_power_state_sequencer_tb
`default_nettype wire
